// ### inc/amos_defines.svh
// Constants for the two-channel analog monitor output select block.
`ifndef AMOS_DEFINES_SVH
`define AMOS_DEFINES_SVH

// ----------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------
`define AMOS_OFS_SEL1 4'h0
`define AMOS_OFS_SEL2 4'h1
`define AMOS_OFS_OFF1 4'h2
`define AMOS_OFS_OFF2 4'h3
`define AMOS_OFS_MUL1 4'h4
`define AMOS_OFS_MUL2 4'h5
`define AMOS_OFS_STAT 4'h6

// ----------------------------------------------------------------
// Reset values and ranges
// ----------------------------------------------------------------
`define AMOS_SEL1_RST 16'h0002
`define AMOS_SEL2_RST 16'h0000
`define AMOS_OFF_RST 16'h0000
`define AMOS_MUL_RST 16'h0064
`define AMOS_SET_MAX 16'sh2710
`define AMOS_SET_MIN (-16'sh2710)

// ----------------------------------------------------------------
// Selection codes
// ----------------------------------------------------------------
`define AMOS_C_SPD 8'h00
`define AMOS_C_SREF 8'h01
`define AMOS_C_FREF 8'h02
`define AMOS_C_PERR 8'h03
`define AMOS_C_AERR 8'h04
`define AMOS_C_PSPD 8'h05
`define AMOS_C_PCMP 8'h08
`define AMOS_C_SFF 8'h09
`define AMOS_C_FFF 8'h0A
`define AMOS_C_GAIN 8'h0B
`define AMOS_C_RCMP 8'h0C

// ----------------------------------------------------------------
// Scaling: signals arrive already in millivolts of monitor level
// except error counts, which are 50 mV per count. Full scale of
// the converter code is 10 V, so 1 LSB = 10000/32768 mV.
// ----------------------------------------------------------------
`define AMOS_ERR_MV 32'sd50
`define AMOS_FLAG_MV 32'sd5000
`define AMOS_GAIN1_MV 32'sd1000
`define AMOS_GAIN2_MV 32'sd2000
`define AMOS_FS_MV 32'sd10000
`define AMOS_LIN_MV 32'sd8000

`endif

// ### inc/amos_pkg.sv
// Types shared by the analog monitor output select block.
package amos_pkg;
    // Monitored quantities in millivolts of monitor level or counts, plus a multiplier and four flags.
    typedef struct packed {
        logic signed [15:0] speed_mv;      // Motor speed, 1 mV per mm/s.
        logic signed [15:0] speed_ref_mv;  // Speed reference.
        logic signed [15:0] force_ref_mv;  // Force reference, 10 mV per %.
        logic signed [15:0] pos_err;       // Position error, reference units.
        logic signed [15:0] amp_err;       // Amplifier error, scale pulses.
        logic signed [15:0] ref_pulse_mv;  // Reference pulse rate before multiply.
        logic signed [15:0] speed_ff_mv;   // Speed feedforward.
        logic signed [15:0] force_ff_mv;   // Force feedforward.
        logic [7:0] pulse_mult;            // Pulse multiplication factor n.
        logic pos_mode;                    // High in position control.
        logic pos_done;                    // Positioning completed.
        logic gain2;                       // Second gain set active.
        logic ref_done;                    // Position reference completed.
    } amos_sig_t;
    // Per-channel settings.
    typedef struct packed {
        logic [7:0] sel;
        logic signed [15:0] mul;
        logic signed [15:0] off;
    } amos_cfg_t;
endpackage : amos_pkg

// ### logic/amos_chan.sv
// One monitor channel: select, scale, invert and clamp to a DAC code.
`timescale 1ns/1ps
`include "amos_defines.svh"
module amos_chan (
    input wire clock,                  // System clock.
    input wire rst_n,                  // Synchronous reset, active low.
    input amos_pkg::amos_sig_t sig,    // Monitored quantities.
    input amos_pkg::amos_cfg_t cfg,    // Channel settings.
    output logic signed [15:0] dac_code, // Converter code.
    output logic clipped               // High when output was clamped.
);
    // ----------------------------------------------------------------
    // Selection
    // ----------------------------------------------------------------
    logic signed [31:0] sel_mv; // Selected level in millivolts.

    // Picks the quantity and brings it to millivolts.
    always_comb begin
        case (cfg.sel)
            `AMOS_C_SPD, `AMOS_C_SREF: sel_mv = 32'(sig.speed_mv);
            `AMOS_C_SFF: sel_mv = 32'(sig.speed_ff_mv);
            `AMOS_C_FREF: sel_mv = 32'(sig.force_ref_mv);
            `AMOS_C_FFF: sel_mv = 32'(sig.force_ff_mv);
            `AMOS_C_PERR: sel_mv = sig.pos_mode ? 32'(sig.pos_err) * `AMOS_ERR_MV : 32'sd0;
            `AMOS_C_AERR: sel_mv = 32'(sig.amp_err) * `AMOS_ERR_MV;
            `AMOS_C_PSPD: sel_mv = 32'(sig.ref_pulse_mv) * $signed({24'h00_0000, sig.pulse_mult});
            `AMOS_C_PCMP: sel_mv = sig.pos_done ? `AMOS_FLAG_MV : 32'sd0;
            `AMOS_C_GAIN: sel_mv = sig.gain2 ? `AMOS_GAIN2_MV : `AMOS_GAIN1_MV;
            `AMOS_C_RCMP: sel_mv = sig.ref_done ? `AMOS_FLAG_MV : 32'sd0;
            default: sel_mv = 32'sd0; // Reserved codes give 0 V
        endcase
        if (cfg.sel == `AMOS_C_SREF) begin
            sel_mv = 32'(sig.speed_ref_mv);
        end
    end

    // ----------------------------------------------------------------
    // Scaling
    // ----------------------------------------------------------------
    logic signed [47:0] out_mv; // Output in units of 0.01 mV.
    logic signed [63:0] code_w; // Unclamped converter code.

    // Forms -(signal*mul + offset), mul in 0.01, offset in 0.1 V.
    always_comb begin
        out_mv = -(48'(sel_mv) * 48'(cfg.mul) + 48'(cfg.off) * 48'sd10000);
        code_w = (64'(out_mv) * 64'sd32768) / (64'(`AMOS_FS_MV) * 64'sd100);
    end

    // Registers the clamped code.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dac_code <= 16'sh0000;
            clipped <= 1'b0;
        end else if (code_w > 64'sd32767) begin
            dac_code <= 16'sh7FFF;
            clipped <= 1'b1;
        end else if (code_w < -64'sd32768) begin
            dac_code <= -16'sh7FFF - 16'sh0001;
            clipped <= 1'b1;
        end else begin
            dac_code <= code_w[15:0];
            clipped <= 1'b0;
        end
    end

    AST_CLAMP_HI: assert property (@(posedge clock) disable iff (!rst_n)
        code_w > 64'sd32767 |=> dac_code == 16'sh7FFF) else $error("no high clamp");
    AST_PERR_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        (cfg.sel == `AMOS_C_PERR && !sig.pos_mode) |-> sel_mv == 32'sd0) else $error("perr not zero");
    AST_FLAG5: assert property (@(posedge clock) disable iff (!rst_n)
        (cfg.sel == `AMOS_C_PCMP && sig.pos_done) |-> sel_mv == 32'sd5000) else $error("flag not 5 V");
    AST_GAIN: assert property (@(posedge clock) disable iff (!rst_n)
        cfg.sel == `AMOS_C_GAIN |-> sel_mv == (sig.gain2 ? 32'sd2000 : 32'sd1000)) else $error("gain level");
    AST_RCMP: assert property (@(posedge clock) disable iff (!rst_n)
        (cfg.sel == `AMOS_C_RCMP && !sig.ref_done) |-> sel_mv == 32'sd0) else $error("rcmp level");
endmodule : amos_chan

// ### logic/amos_top.sv
// Analog monitor output select: register slave and two channels.
`timescale 1ns/1ps
`include "amos_defines.svh"
module amos_top (
    input wire clock,                          // 200 MHz clock.
    input wire rst_n,                          // Synchronous reset, active low.
    input wire [3:0] avs_address,              // Word address.
    input wire avs_read,                       // Read request.
    input wire avs_write,                      // Write request.
    input wire [31:0] avs_writedata,           // Write data.
    input wire [3:0] avs_byteenable,           // Byte enables.
    output logic [31:0] avs_readdata,          // Read data.
    output logic avs_waitrequest,              // Wait request.
    output logic [1:0] avs_response,           // 00 okay, 10 slave error.
    input amos_pkg::amos_sig_t mon_sig,        // Monitored quantities.
    output logic signed [15:0] dac_one,        // Channel one converter code.
    output logic signed [15:0] dac_two         // Channel two converter code.
);
    // ----------------------------------------------------------------
    // Settings
    // ----------------------------------------------------------------
    amos_pkg::amos_cfg_t cfg_reg [2]; // Per-channel settings.
    logic [1:0] clip;                 // Clamp flags per channel.
    logic done_reg;                   // Answer phase flag.
    logic signed [15:0] wd;           // Low half of write data.
    logic signed [15:0] wlim;         // Write data clamped to range.
    logic hit;                        // Address is mapped.

    // Clamps offset and multiplier writes to -10000..10000.
    always_comb begin
        wd = avs_writedata[15:0];
        if (wd > `AMOS_SET_MAX) begin
            wlim = `AMOS_SET_MAX;
        end else if (wd < `AMOS_SET_MIN) begin
            wlim = `AMOS_SET_MIN;
        end else begin
            wlim = wd;
        end
        hit = avs_address <= `AMOS_OFS_STAT;
    end

    // One wait cycle, then answer on the second edge.
    always_comb begin
        avs_waitrequest = (avs_read | avs_write) & ~done_reg;
    end

    // Tracks the answer phase.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (avs_read | avs_write) & ~done_reg;
        end
    end

    // Writes settings; they act on the very next cycle.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_reg[0] <= '{sel: 8'(`AMOS_SEL1_RST), mul: `AMOS_MUL_RST, off: `AMOS_OFF_RST};
            cfg_reg[1] <= '{sel: 8'(`AMOS_SEL2_RST), mul: `AMOS_MUL_RST, off: `AMOS_OFF_RST};
        end else if (avs_write && done_reg && avs_byteenable[1:0] == 2'b11) begin
            case (avs_address)
                `AMOS_OFS_SEL1: cfg_reg[0].sel <= avs_writedata[7:0];
                `AMOS_OFS_SEL2: cfg_reg[1].sel <= avs_writedata[7:0];
                `AMOS_OFS_OFF1: cfg_reg[0].off <= wlim;
                `AMOS_OFS_OFF2: cfg_reg[1].off <= wlim;
                `AMOS_OFS_MUL1: cfg_reg[0].mul <= wlim;
                `AMOS_OFS_MUL2: cfg_reg[1].mul <= wlim;
                default: ;
            endcase
        end
    end

    // Returns read data and response during the answer cycle.
    always_comb begin
        avs_readdata = 32'h0000_0000;
        avs_response = hit ? 2'b00 : 2'b10;
        case (avs_address)
            `AMOS_OFS_SEL1: avs_readdata = {24'h00_0000, cfg_reg[0].sel};
            `AMOS_OFS_SEL2: avs_readdata = {24'h00_0000, cfg_reg[1].sel};
            `AMOS_OFS_OFF1: avs_readdata = {{16{cfg_reg[0].off[15]}}, cfg_reg[0].off};
            `AMOS_OFS_OFF2: avs_readdata = {{16{cfg_reg[1].off[15]}}, cfg_reg[1].off};
            `AMOS_OFS_MUL1: avs_readdata = {{16{cfg_reg[0].mul[15]}}, cfg_reg[0].mul};
            `AMOS_OFS_MUL2: avs_readdata = {{16{cfg_reg[1].mul[15]}}, cfg_reg[1].mul};
            `AMOS_OFS_STAT: avs_readdata = {30'h0000_0000, clip};
            default: avs_readdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    logic signed [15:0] codes [2]; // Channel codes.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            amos_chan u_chan (
                .clock(clock),
                .rst_n(rst_n),
                .sig(mon_sig),
                .cfg(cfg_reg[g]),
                .dac_code(codes[g]),
                .clipped(clip[g])
            );
        end
    endgenerate

    assign dac_one = codes[0];
    assign dac_two = codes[1];

    AST_WAIT_ONE: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("answer late");
    AST_OFF_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_reg[0].off <= 16'sh2710 && cfg_reg[0].off >= -16'sh2710 &&
        cfg_reg[1].off <= 16'sh2710 && cfg_reg[1].off >= -16'sh2710) else $error("offset range");
    AST_MUL_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_reg[0].mul <= 16'sh2710 && cfg_reg[0].mul >= -16'sh2710 &&
        cfg_reg[1].mul <= 16'sh2710 && cfg_reg[1].mul >= -16'sh2710) else $error("mult range");
endmodule : amos_top

// ### testbench/amos_recorder.sv
// Measuring instrument model that samples both monitor channel codes.
`timescale 1ns/1ps
module amos_recorder (
    input wire clock,                    // Sampling clock.
    input wire signed [15:0] ch_one,     // Channel one converter code.
    input wire signed [15:0] ch_two,     // Channel two converter code.
    output logic signed [15:0] seen_one, // Last sample of channel one.
    output logic signed [15:0] seen_two  // Last sample of channel two.
);
    // ------------------------------------------------------------
    // Sampling
    // ------------------------------------------------------------
    // The recorder takes the full 16-bit code each clock, one clock late.
    always_ff @(posedge clock) begin
        seen_one <= ch_one;
        seen_two <= ch_two;
    end
endmodule : amos_recorder

// ### testbench/analog_monitor_output_select_bench.sv
// Self-checking bench for the two-channel analog monitor output block.
`timescale 1ns/1ps
module analog_monitor_output_select_bench;
    logic clock = 1'b0; // 200 MHz clock.
    logic rst_n = 1'b0; // Synchronous reset, active low.
    logic [3:0] avs_address = 4'h0; // Register word index.
    logic avs_read = 1'b0; // Read request.
    logic avs_write = 1'b0; // Write request.
    logic [31:0] avs_writedata = 32'h0000_0000; // Write data.
    logic [3:0] avs_byteenable = 4'hf; // Byte enables.
    logic [31:0] avs_readdata; // Read data.
    logic avs_waitrequest; // Wait request.
    logic [1:0] avs_response; // Response code.
    amos_pkg::amos_sig_t mon_sig = '0; // Monitored quantities.
    amos_pkg::amos_sig_t s; // Next set of quantities.
    logic [159:0] raw; // Random bits for the quantities.
    logic signed [15:0] dac_one, dac_two, rec_one, rec_two; // Codes and samples.
    int failures = 0; // Mismatch count.
    int samples_checked = 0; // Comparison count.
    logic [31:0] rd; // Last read data.
    logic [1:0] rr; // Last response.
    amos_pkg::amos_cfg_t cfg [2]; // Settings of both channels.
    logic [7:0] codes [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0a, 8'h0b,
                               8'h0c}; // Valid codes only; reserved ones are never written.
    logic [31:0] rst_val [6] = '{32'h0000_0002, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                 32'h0000_0064, 32'h0000_0064}; // Register reset values.

    always #2.5 clock = ~clock;

    amos_top dut (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
                  .avs_readdata, .avs_waitrequest, .avs_response, .mon_sig, .dac_one, .dac_two);
    amos_recorder rec (.clock, .ch_one(dac_one), .ch_two(dac_two), .seen_one(rec_one), .seen_two(rec_two));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Prints the counts and the verdict, then stops the run.
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // Compares one value and reports a mismatch.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One bus cycle, held until waitrequest is seen low at an edge.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clock);
            n++;
            if (n > 50) begin
                failures++;
                conclude();
            end
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rr = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // Writes selection, offset and multiplier of one channel.
    task automatic setcfg(input int c);
        bus(1'b1, 4'(c), 32'(cfg[c].sel), 4'hf);
        bus(1'b1, 4'(2 + c), 32'(cfg[c].off), 4'hf);
        bus(1'b1, 4'(4 + c), 32'(cfg[c].mul), 4'hf);
    endtask : setcfg

    // Works out the code a channel should show for given settings.
    function automatic logic signed [15:0] expect_code(amos_pkg::amos_cfg_t c, amos_pkg::amos_sig_t q);
        longint v;
        case (c.sel)
            8'h00: v = q.speed_mv;
            8'h01: v = q.speed_ref_mv;
            8'h02: v = q.force_ref_mv;
            8'h03: v = q.pos_mode ? longint'(q.pos_err) * 50 : 0;
            8'h04: v = longint'(q.amp_err) * 50;
            8'h05: v = longint'(q.ref_pulse_mv) * longint'(q.pulse_mult);
            8'h08: v = q.pos_done ? 5000 : 0;
            8'h09: v = q.speed_ff_mv;
            8'h0a: v = q.force_ff_mv;
            8'h0b: v = q.gain2 ? 2000 : 1000;
            8'h0c: v = q.ref_done ? 5000 : 0;
            default: v = 0;
        endcase
        v = -(v * longint'(c.mul) + longint'(c.off) * 10000) * 32768 / 1000000;
        if (v > 32767) v = 32767;
        if (v < -32768) v = -32768;
        return 16'(v);
    endfunction : expect_code

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h3ed4));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 0; a < 6; a++) begin
            bus(1'b0, 4'(a), 32'h0000_0000, 4'hf);
            check("reset value", rst_val[a], rd);
        end
        check("dac one at reset", 32'h0000_0000, 32'(dac_one));
        $display("Test reset values done");
        bus(1'b0, 4'h7, 32'h0000_0000, 4'hf);
        check("unmapped response", 32'h0000_0002, 32'(rr));
        bus(1'b1, 4'h2, 32'h0000_0100, 4'hc);
        bus(1'b0, 4'h2, 32'h0000_0000, 4'hf);
        check("offset after partial write", 32'h0000_0000, rd);
        bus(1'b1, 4'h4, 32'h0000_4e20, 4'hf);
        bus(1'b0, 4'h4, 32'h0000_0000, 4'hf);
        check("multiplier clamp", 32'h0000_2710, rd);
        bus(1'b1, 4'h3, 32'hffff_b1e0, 4'hf);
        bus(1'b0, 4'h3, 32'h0000_0000, 4'hf);
        check("offset clamp", 32'hffff_d8f0, rd);
        $display("Test register access done");
        for (int i = 0; i < 60; i++) begin
            raw = {$urandom, $urandom, $urandom, $urandom, $urandom};
            s = raw[139:0];
            for (int c = 0; c < 2; c++) begin
                cfg[c].sel = codes[(i < 28) ? (i + c) % 11 : $urandom_range(10)];
                cfg[c].mul = 16'($urandom_range(20000)) - 16'sh2710;
                cfg[c].off = 16'($urandom_range(200)) - 16'sh0064;
            end
            if (i == 0) begin
                cfg[0] = '{sel: 8'h0b, mul: 16'sh0064, off: 16'sh0000};
                cfg[1] = '{sel: 8'h00, mul: 16'sh2710, off: 16'sh0000};
                s.speed_mv = 16'sh4e20;
            end
            mon_sig <= s;
            setcfg(0);
            setcfg(1);
            repeat (3) @(posedge clock);
            check("channel one code", 32'(expect_code(cfg[0], s)), 32'(rec_one));
            check("channel two code", 32'(expect_code(cfg[1], s)), 32'(rec_two));
            if (i == 0) begin
                // Channel two is driven far past full scale, channel one stays inside it.
                bus(1'b0, 4'h6, 32'h0000_0000, 4'hf);
                check("clamp flags", 32'h0000_0002, rd);
            end
        end
        $display("Test channel outputs done");
        conclude();
    end
endmodule : analog_monitor_output_select_bench
